// [design/output_step_sequencer.sv]
// Step sequencer with APB register access and two stored program sets
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "step_seq_regs.svh"
module output_step_sequencer
  import step_seq_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
)
(
  input  wire logic        pclk,       // System clock
  input  wire logic        presetn,    // Async reset, active low
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB enable
  input  wire logic        pwrite,     // APB direction
  input  wire logic [7:0]  paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error on unmapped address
  output logic      [14:0] dc_level,   // DC output level, 0.1 V
  output logic      [14:0] ac_level,   // AC amplitude, 0.1 V units
  output logic      [1:0]  step_sync,  // Step sync code
  output logic      [1:0]  seq_state   // Idle, Run or Hold
);

  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535)
  begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  logic       out_en_q;
  logic       comb_q;
  logic       high_q;
  logic       sel_open_q;
  logic [7:0] br0_q;
  logic [7:0] br1_q;
  logic [7:0] sel_q;
  seq_state_t state_q;
  logic [7:0] cur_q;
  logic       enter_q;
  logic       end_hold_q;
  logic [23:0] cnt_q;
  logic [23:0] dur_q;
  step_cfg_t  ecfg_q;
  logic [15:0] pre_q;
  logic [1:0] sync_q;
  logic [14:0] dc_port_q;
  logic [14:0] ac_port_q;

  logic [23:0] time_mem [0:511];
  volt_t       dc_mem   [0:511];
  volt_t       ac_mem   [0:511];
  step_cfg_t   cfg_mem  [0:511];

  logic       acc_wr;
  logic       hit;
  logic [8:0] pidx;
  logic [8:0] eidx;
  logic       tick;
  logic       cmd_go;
  logic [2:0] cmd;
  logic       step_end;
  logic       seq_end;
  logic       toggle;
  logic [7:0] br_tgt;

  assign acc_wr = psel && penable && pwrite;
  assign pidx   = {comb_q, sel_q};
  assign eidx   = {comb_q, cur_q};
  assign cmd    = pwdata[2:0];
  assign tick   = (pre_q == TICK_LAST);
  assign toggle = acc_wr && paddr == `ADDR_CTRL && pwdata[`CTRL_OUT_EN] != out_en_q;
  assign cmd_go = acc_wr && paddr == `ADDR_CMD && sel_open_q && out_en_q;
  assign br_tgt = (cmd == `CMD_BR0) ? br0_q : br1_q;
  assign step_end = state_q == ST_RUN && !enter_q && tick && (cnt_q + `TIME_MIN == dur_q);
  assign seq_end  = step_end && !cmd_go;
  assign hit    = paddr[1:0] == 2'h0 && paddr <= `ADDR_OUT_AC;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  function automatic volt_t clamp_v(input logic signed [15:0] v,
                                    input logic signed [15:0] lo,
                                    input logic signed [15:0] hi);
    if (v < lo)
    begin
      return lo[14:0];
    end
    if (v > hi)
    begin
      return hi[14:0];
    end
    return v[14:0];
  endfunction

  function automatic logic [23:0] clamp_t(input logic [23:0] t);
    if (t < `TIME_MIN)
    begin
      return `TIME_MIN;
    end
    if (t > `TIME_MAX)
    begin
      return `TIME_MAX;
    end
    return t;
  endfunction

  // Free running prescaler; a resumed step may lose up to one tick of phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_q <= 16'h0000;
    else if (tick)
      pre_q <= 16'h0000;
    else
      pre_q <= pre_q + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_en_q <= 1'b0;
      comb_q   <= 1'b0;
      high_q   <= 1'b0;
      br0_q    <= 8'h00;
      br1_q    <= 8'h00;
      sel_q    <= `STEP_FIRST;
    end
    else if (acc_wr)
    begin
      if (paddr == `ADDR_CTRL)
      begin
        out_en_q <= pwdata[`CTRL_OUT_EN];
        comb_q   <= pwdata[`CTRL_COMB];
        high_q   <= pwdata[`CTRL_HIGH];
      end
      if (paddr == `ADDR_BRANCH0)
        br0_q <= pwdata[7:0];
      if (paddr == `ADDR_BRANCH1)
        br1_q <= pwdata[7:0];
      if (paddr == `ADDR_STEP_SEL && pwdata[7:0] != 8'h00)
        sel_q <= pwdata[7:0];
    end
  end

  // Selection window: opened by a write, closed by a command or an enable toggle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_open_q <= 1'b0;
    else if (toggle || cmd_go)
      sel_open_q <= 1'b0;
    else if (acc_wr && paddr == `ADDR_SELECT && out_en_q)
      sel_open_q <= 1'b1;
  end

  // Writes land in the set of the current mode at once, clamped by the present range
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 512; i++)
      begin
        time_mem[i] <= `TIME_MIN;
        dc_mem[i]   <= 15'h0000;
        ac_mem[i]   <= 15'h0000;
        cfg_mem[i]  <= 10'h000;
      end
    end
    else if (acc_wr)
    begin
      unique case (paddr)
        `ADDR_STEP_TIME: time_mem[pidx] <= clamp_t(pwdata[23:0]);
        `ADDR_STEP_DC:   dc_mem[pidx] <= clamp_v(pwdata[15:0],
                           high_q ? -$signed(`DC_LIM_HI) : -$signed(`DC_LIM_LO),
                           high_q ? $signed(`DC_LIM_HI) : $signed(`DC_LIM_LO));
        `ADDR_STEP_AC:   ac_mem[pidx] <= clamp_v(pwdata[15:0], 16'h0000,
                           cfg_mem[pidx][`CFG_PP] ?
                             (high_q ? `AC_PP_HI : `AC_PP_LO) :
                             (high_q ? `AC_RMS_HI : `AC_RMS_LO));
        `ADDR_STEP_CFG:  cfg_mem[pidx] <= {pwdata[`CFG_PP] & pwdata[`CFG_ARB],
                                           pwdata[8:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q    <= ST_IDLE;
      cur_q      <= `STEP_FIRST;
      enter_q    <= 1'b0;
      end_hold_q <= 1'b0;
    end
    else
    begin
      enter_q <= 1'b0;
      if (cmd_go)
      begin
        unique case (cmd)
          `CMD_START:
          begin
            if (state_q == ST_IDLE)
            begin
              state_q    <= ST_RUN;
              cur_q      <= `STEP_FIRST;
              enter_q    <= 1'b1;
              end_hold_q <= 1'b0;
            end
            else if (state_q == ST_HOLD)
            begin
              state_q <= ST_RUN;
              end_hold_q <= 1'b0;
              if (end_hold_q && cur_q == `STEP_LAST)
                state_q <= ST_IDLE;
              else if (end_hold_q)
              begin
                cur_q   <= cur_q + 8'h01;
                enter_q <= 1'b1;
              end
            end
          end
          `CMD_STOP: state_q <= ST_IDLE;
          `CMD_HOLD:
          begin
            // A manual hold must never inherit an end-of-step hold left by an earlier run
            if (state_q == ST_RUN)
            begin
              state_q    <= ST_HOLD;
              end_hold_q <= 1'b0;
            end
          end
          `CMD_BR0, `CMD_BR1:
          begin
            if (state_q != ST_IDLE && br_tgt != 8'h00)
            begin
              cur_q      <= br_tgt;
              enter_q    <= 1'b1;
              end_hold_q <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      else if (step_end)
      begin
        unique case (ecfg_q[`CFG_END_LSB +: 2])
          `END_CONT:
          begin
            if (cur_q == `STEP_LAST)
              state_q <= ST_IDLE;
            else
            begin
              cur_q   <= cur_q + 8'h01;
              enter_q <= 1'b1;
            end
          end
          `END_STOP: state_q <= ST_IDLE;
          default:
          begin
            state_q    <= ST_HOLD;
            end_hold_q <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= 24'h00_0000;
      dur_q  <= `TIME_MIN;
      ecfg_q <= 10'h000;
    end
    else if (enter_q)
    begin
      cnt_q  <= 24'h00_0000;
      dur_q  <= time_mem[eidx];
      ecfg_q <= cfg_mem[eidx];
    end
    // A step end lost to a command leaves the count one short, so the next tick ends it
    else if (state_q == ST_RUN && tick && !step_end)
      cnt_q <= cnt_q + `TIME_MIN;
  end

  // Channel 0 is DC, channel 1 is AC; the sweep walks one unit per clock behind
  // a per-tick error sum, and the end of step snaps to the exact target
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    volt_t        tgt_q;
    volt_t        out_q;
    logic [1:0]   typ_q;
    logic [25:0]  acc_q;
    volt_t        mem_t;
    logic [1:0]   mem_typ;
    logic signed [15:0] diff;
    logic [15:0]  mag;

    assign mem_t   = (c == 0) ? dc_mem[eidx] : ac_mem[eidx];
    assign mem_typ = cfg_mem[eidx][2*c +: 2];
    assign diff    = {tgt_q[14], tgt_q} - {out_q[14], out_q};
    assign mag     = diff[15] ? 16'(-diff) : diff;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        tgt_q <= 15'h0000;
        out_q <= 15'h0000;
        typ_q <= `XT_FIXED;
        acc_q <= 26'h000_0000;
      end
      else if (enter_q)
      begin
        tgt_q <= mem_t;
        typ_q <= mem_typ;
        acc_q <= 26'h000_0000;
        if (mem_typ != `XT_KEEP && mem_typ != `XT_SWEEP)
          out_q <= mem_t;
      end
      else if (seq_end)
      begin
        acc_q <= 26'h000_0000;
        if (typ_q != `XT_KEEP)
          out_q <= tgt_q;
      end
      else if (state_q == ST_RUN && typ_q == `XT_SWEEP)
      begin
        if (tick)
          acc_q <= acc_q + 26'(mag);
        else if (out_q != tgt_q && acc_q >= 26'(dur_q))
        begin
          acc_q <= acc_q - 26'(dur_q);
          out_q <= diff[15] ? out_q - 15'h0001 : out_q + 15'h0001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dc_port_q <= 15'h0000;
      ac_port_q <= 15'h0000;
      sync_q    <= 2'h0;
    end
    else
    begin
      dc_port_q <= comb_q ? g_ch[0].out_q : 15'h0000;
      ac_port_q <= g_ch[1].out_q;
      if (state_q == ST_IDLE)
        sync_q <= 2'h0;
      else
        sync_q <= ecfg_q[`CFG_SYNC_LSB +: 2];
    end
  end

  assign dc_level  = dc_port_q;
  assign ac_level  = ac_port_q;
  // Gated by the state itself so the code is low in the very cycle Idle is reached
  assign step_sync = (state_q == ST_IDLE) ? 2'h0 : sync_q;
  assign seq_state = state_q;

  // Read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      unique case (paddr)
        `ADDR_CTRL:      prdata <= {29'h0, high_q, comb_q, out_en_q};
        `ADDR_SELECT:    prdata <= {31'h0, sel_open_q};
        `ADDR_BRANCH0:   prdata <= {24'h0, br0_q};
        `ADDR_BRANCH1:   prdata <= {24'h0, br1_q};
        `ADDR_STEP_SEL:  prdata <= {24'h0, sel_q};
        `ADDR_STEP_TIME: prdata <= {8'h0, time_mem[pidx]};
        `ADDR_STEP_DC:   prdata <= 32'(dc_mem[pidx]);
        `ADDR_STEP_AC:   prdata <= {17'h0, ac_mem[pidx]};
        `ADDR_STEP_CFG:  prdata <= {22'h0, cfg_mem[pidx]};
        `ADDR_STATUS:    prdata <= {14'h0, sync_q, cur_q, 5'h0, sel_open_q, state_q};
        `ADDR_OUT_DC:    prdata <= 32'(g_ch[0].out_q);
        `ADDR_OUT_AC:    prdata <= {17'h0, g_ch[1].out_q};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  sequence seq_cmd(logic [2:0] code);
    cmd_go && cmd == code;
  endsequence

  chk_start_runs: assert property (@(posedge pclk) disable iff (!presetn)
    seq_cmd(`CMD_START) and (state_q == ST_IDLE) |=> state_q == ST_RUN ##1 cur_q == `STEP_FIRST)
    else $error("start did not run from first step");
  chk_stop_idles: assert property (@(posedge pclk) disable iff (!presetn)
    seq_cmd(`CMD_STOP) |=> state_q == ST_IDLE && step_sync == 2'h0 ##1 step_sync == 2'h0)
    else $error("stop did not reach idle");
  chk_hold_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    seq_cmd(`CMD_HOLD) and (state_q == ST_RUN) |=> state_q == ST_HOLD && $stable(cur_q))
    else $error("hold lost position");
  chk_branch_goes: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && (cmd == `CMD_BR0 || cmd == `CMD_BR1) && br_tgt != 8'h00 && state_q != ST_IDLE
    |=> cur_q == $past(br_tgt) && enter_q)
    else $error("branch missed target");
  chk_branch_null: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && (cmd == `CMD_BR0 || cmd == `CMD_BR1) && br_tgt == 8'h00
    |=> $stable(cur_q) && $stable(state_q))
    else $error("unset branch acted");
  chk_off_refused: assert property (@(posedge pclk) disable iff (!presetn)
    !out_en_q && acc_wr && paddr == `ADDR_CMD && !step_end |=> $stable(state_q) && $stable(cur_q))
    else $error("command taken with output off");
  chk_toggle_closes: assert property (@(posedge pclk) disable iff (!presetn)
    toggle |=> !sel_open_q)
    else $error("selection survived enable toggle");
  chk_dc_masked: assert property (@(posedge pclk) disable iff (!presetn)
    !comb_q ##1 !comb_q |-> dc_level == 15'h0000)
    else $error("dc level out of combined mode");
  chk_sweep_end: assert property (@(posedge pclk) disable iff (!presetn)
    seq_end && g_ch[0].typ_q == `XT_SWEEP |=> g_ch[0].out_q == $past(g_ch[0].tgt_q))
    else $error("sweep missed target at step end");
  chk_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick [*8])
    else $error("tick spacing too short");
  chk_idle_sync: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_IDLE ##1 state_q == ST_IDLE |-> step_sync == 2'h0)
    else $error("sync code high in idle");

endmodule // output_step_sequencer

// [shared/step_seq_pkg.sv]
// Types shared by the step sequencer
package step_seq_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} seq_state_t;
  typedef logic signed [14:0] volt_t;
  typedef logic [9:0]         step_cfg_t;
endpackage

// [shared/step_seq_regs.svh]
// Register map, field layout, limits and timing constants of the step sequencer
`ifndef STEP_SEQ_REGS_SVH
`define STEP_SEQ_REGS_SVH
`define ADDR_CTRL      8'h00
`define ADDR_SELECT    8'h04
`define ADDR_CMD       8'h08
`define ADDR_BRANCH0   8'h0C
`define ADDR_BRANCH1   8'h10
`define ADDR_STEP_SEL  8'h14
`define ADDR_STEP_TIME 8'h18
`define ADDR_STEP_DC   8'h1C
`define ADDR_STEP_AC   8'h20
`define ADDR_STEP_CFG  8'h24
`define ADDR_STATUS    8'h28
`define ADDR_OUT_DC    8'h2C
`define ADDR_OUT_AC    8'h30
`define CTRL_OUT_EN    0
`define CTRL_COMB      1
`define CTRL_HIGH      2
`define CMD_START      3'h1
`define CMD_STOP       3'h2
`define CMD_HOLD       3'h3
`define CMD_BR0        3'h4
`define CMD_BR1        3'h5
`define CFG_END_LSB    4
`define CFG_SYNC_LSB   6
`define CFG_ARB        8
`define CFG_PP         9
`define XT_FIXED       2'h0
`define XT_KEEP        2'h1
`define XT_SWEEP       2'h2
`define END_CONT       2'h0
`define END_STOP       2'h1
`define STEP_FIRST     8'h01
`define STEP_LAST      8'hFF
`define TIME_MIN       24'h00_0001
`define TIME_MAX       24'h98_967F
`define DC_LIM_LO      16'h0898
`define DC_LIM_HI      16'h1130
`define AC_RMS_LO      16'h060E
`define AC_PP_LO       16'h1130
`define AC_RMS_HI      16'h0C1C
`define AC_PP_HI       16'h2260
`define TICK_NS        32'h0001_86A0
`define CLK_NS         32'h0000_0064
`endif

// [testbench/panel_host_model.sv]
// APB master standing in for the operator panel or remote host
`timescale 1ns/100ps
module panel_host_model
(
  input  wire logic        pclk,     // System clock
  output logic             psel,     // APB select
  output logic             penable,  // APB enable
  output logic             pwrite,   // APB direction
  output logic      [7:0]  paddr,    // APB byte address
  output logic      [31:0] pwdata,   // APB write data
  input  wire logic [31:0] prdata,   // APB read data
  input  wire logic        pready,   // APB ready
  input  wire logic        pslverr   // APB error
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // Request is held until pready is seen at a rising edge, whatever the latency
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // panel_host_model

// [testbench/test_output_step_sequencer.sv]
// Self-checking bench for the step sequencer
`timescale 1ns/100ps
`include "step_seq_regs.svh"
module test_output_step_sequencer;
  import step_seq_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [14:0] dc_level;
  logic [14:0] ac_level;
  logic [1:0]  step_sync;
  logic [1:0]  seq_state;
  int          miscompares = 0;
  int          checks_done = 0;
  logic [31:0] v;
  logic        e;

  // Nine clocks per tick: short steps, yet the tick spacing assertion still holds
  output_step_sequencer #(.TICK_CYCLES(9)) dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dc_level(dc_level),
    .ac_level(ac_level), .step_sync(step_sync), .seq_state(seq_state)
  );

  panel_host_model host
  (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic end_of_test();
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        x;
    host.xfer(1'b1, a, d, r, x);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic        x;
    host.xfer(1'b0, a, 32'h0000_0000, r, x);
    check(r & m, exp);
  endtask

  // Each command needs its own selection
  task automatic cmd(input logic [31:0] c);
    wr(`ADDR_SELECT, 32'h0000_0000);
    wr(`ADDR_CMD, c);
  endtask

  // Config goes before the AC target so the peak-to-peak limit is picked up
  task automatic prog(input logic [31:0] s, input logic [31:0] t, input logic [31:0] dc,
                      input logic [31:0] cfg, input logic [31:0] ac);
    wr(`ADDR_STEP_SEL, s);
    wr(`ADDR_STEP_TIME, t);
    wr(`ADDR_STEP_DC, dc);
    wr(`ADDR_STEP_CFG, cfg);
    wr(`ADDR_STEP_AC, ac);
  endtask

  task automatic wait_for(input logic dc, input logic [14:0] exp);
    int n;
    n = 0;
    while ((dc ? dc_level : {13'h0000, seq_state}) !== exp && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    check({17'h0_0000, dc ? dc_level : {13'h0000, seq_state}}, {17'h0_0000, exp});
  endtask

  initial
  begin
    #2_000_000;
    miscompares++;
    end_of_test();
  end

  initial
  begin
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({30'h0, step_sync}, 32'h0000_0000);
    rchk(`ADDR_STEP_SEL, 32'h0000_00FF, 32'h0000_0001);
    host.xfer(1'b0, 8'h34, 32'h0000_0000, v, e);
    check({31'h0, e}, 32'h0000_0001);
    check(v, 32'h0000_0000);
    // Output off: selection never opens and commands do nothing
    wr(`ADDR_CTRL, 32'h0000_0000);
    cmd(`CMD_START);
    repeat (3) @(posedge pclk);
    check({30'h0, seq_state}, 32'h0000_0000);
    rchk(`ADDR_STATUS, 32'h0000_0004, 32'h0000_0000);
    wr(`ADDR_CTRL, 32'h0000_0001);
    wr(`ADDR_SELECT, 32'h0000_0000);
    rchk(`ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
    wr(`ADDR_CTRL, 32'h0000_0000);
    wr(`ADDR_CTRL, 32'h0000_0001);
    rchk(`ADDR_STATUS, 32'h0000_0004, 32'h0000_0000);
    wr(`ADDR_CMD, `CMD_START);
    repeat (3) @(posedge pclk);
    check({30'h0, seq_state}, 32'h0000_0000);
    // Limits, combined mode, low and high range
    wr(`ADDR_CTRL, 32'h0000_0003);
    wr(`ADDR_STEP_SEL, 32'h0000_0000);
    rchk(`ADDR_STEP_SEL, 32'h0000_00FF, 32'h0000_0001);
    wr(`ADDR_STEP_SEL, 32'h0000_0009);
    wr(`ADDR_STEP_TIME, 32'h0000_0000);
    rchk(`ADDR_STEP_TIME, 32'h00FF_FFFF, 32'h0000_0001);
    wr(`ADDR_STEP_TIME, 32'h00FF_FFFF);
    rchk(`ADDR_STEP_TIME, 32'h00FF_FFFF, 32'h0098_967F);
    wr(`ADDR_STEP_DC, 32'h0000_0BB8);
    rchk(`ADDR_STEP_DC, 32'h0000_7FFF, 32'h0000_0898);
    wr(`ADDR_CTRL, 32'h0000_0007);
    wr(`ADDR_STEP_DC, 32'hFFFF_EC78);
    rchk(`ADDR_STEP_DC, 32'h0000_7FFF, 32'h0000_6ED0);
    wr(`ADDR_STEP_AC, 32'h0000_0FA0);
    rchk(`ADDR_STEP_AC, 32'h0000_FFFF, 32'h0000_0C1C);
    wr(`ADDR_STEP_CFG, 32'h0000_0300);
    wr(`ADDR_STEP_AC, 32'h0000_270F);
    rchk(`ADDR_STEP_AC, 32'h0000_FFFF, 32'h0000_2260);
    wr(`ADDR_CTRL, 32'h0000_0003);
    wr(`ADDR_STEP_AC, 32'h0000_270F);
    rchk(`ADDR_STEP_AC, 32'h0000_FFFF, 32'h0000_1130);
    wr(`ADDR_STEP_CFG, 32'h0000_0200);
    rchk(`ADDR_STEP_CFG, 32'h0000_0200, 32'h0000_0000);
    wr(`ADDR_STEP_AC, 32'h0000_07D0);
    rchk(`ADDR_STEP_AC, 32'h0000_FFFF, 32'h0000_060E);
    // The AC-only set must not disturb the combined set
    wr(`ADDR_CTRL, 32'h0000_0001);
    wr(`ADDR_STEP_AC, 32'h0000_0064);
    rchk(`ADDR_STEP_AC, 32'h0000_FFFF, 32'h0000_0064);
    wr(`ADDR_CTRL, 32'h0000_0003);
    rchk(`ADDR_STEP_AC, 32'h0000_FFFF, 32'h0000_060E);
    // Step 1 fixed, step 2 sweeps and holds, step 3 keeps and stops
    prog(32'h0000_0001, 32'h0000_0003, 32'h0000_0064, 32'h0000_0040, 32'h0000_0000);
    prog(32'h0000_0002, 32'h0000_0005, 32'h0000_012C, 32'h0000_00AA, 32'h0000_01F4);
    prog(32'h0000_0003, 32'h0000_000A, 32'h0000_0000, 32'h0000_00D5, 32'h0000_0000);
    cmd(`CMD_START);
    wait_for(1'b0, 15'h0001);
    wait_for(1'b1, 15'h0064);
    wait_for(1'b0, 15'h0002);
    wait_for(1'b1, 15'h012C);
    check({17'h0_0000, ac_level}, 32'h0000_01F4);
    cmd(`CMD_BR0);
    repeat (3) @(posedge pclk);
    check({30'h0, seq_state}, 32'h0000_0002);
    rchk(`ADDR_STATUS, 32'h0000_FF00, 32'h0000_0200);
    wr(`ADDR_BRANCH1, 32'h0000_0001);
    cmd(`CMD_BR1);
    rchk(`ADDR_STATUS, 32'h0000_FF03, 32'h0000_0102);
    cmd(`CMD_START);
    wait_for(1'b0, 15'h0001);
    rchk(`ADDR_STATUS, 32'h0000_FF00, 32'h0000_0100);
    wait_for(1'b0, 15'h0002);
    cmd(`CMD_START);
    wait_for(1'b0, 15'h0001);
    repeat (6) @(posedge pclk);
    check({17'h0_0000, dc_level}, 32'h0000_012C);
    check({30'h0, step_sync}, 32'h0000_0003);
    wait_for(1'b0, 15'h0000);
    check({30'h0, step_sync}, 32'h0000_0000);
    // Hold freezes the step position
    cmd(`CMD_START);
    wait_for(1'b0, 15'h0001);
    cmd(`CMD_HOLD);
    wait_for(1'b0, 15'h0002);
    host.xfer(1'b0, `ADDR_STATUS, 32'h0000_0000, v, e);
    repeat (40) @(posedge pclk);
    rchk(`ADDR_STATUS, 32'h0000_FF03, (v & 32'h0000_FF00) | 32'h0000_0002);
    cmd(`CMD_STOP);
    wait_for(1'b0, 15'h0000);
    check({30'h0, step_sync}, 32'h0000_0000);
    wr(`ADDR_CTRL, 32'h0000_0001);
    wait_for(1'b1, 15'h0000);
    end_of_test();
  end
endmodule // test_output_step_sequencer
